// ==== pts_chan_mux.sv ====
// one channel's time base multiplexer
`timescale 1ns/1ns
module pts_chan_mux (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// selection and timer ticks
	input wire logic [1:0] sel,
	input wire pts_pkg::pts_ticks_s ticks,
	// chosen time base tick
	output logic tick_out
);
	wire logic tick_d;

	// reserved code falls back to the first timer
	assign tick_d = (sel == pts_pkg::SEL_TMR_B) ? ticks.tick_b :
		(sel == pts_pkg::SEL_TMR_C) ? ticks.tick_c : ticks.tick_a;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= tick_d;
		end
	end
endmodule

// ==== pts_pkg.sv ====
// package for the pwm time base selection register
package pts_pkg;
	localparam logic [3:0] REG_CHOICE0_OFS = 4'h0;
	localparam logic [3:0] REG_STATUS_OFS = 4'h4;
	localparam logic [7:0] CHOICE0_RESET = 8'h00;
	localparam int CHAN4_LSB = 6;
	localparam int CHAN3_LSB = 4;
	localparam int CHAN2_LSB = 2;
	localparam int CHAN1_LSB = 0;
	localparam int NUM_CHAN = 4;
	localparam logic [1:0] SEL_TMR_A = 2'h0;
	localparam logic [1:0] SEL_TMR_B = 2'h1;
	localparam logic [1:0] SEL_TMR_C = 2'h2;
	localparam logic [1:0] SEL_RSVD = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one tick pulse from each period timer
	typedef struct packed {
		logic tick_c;
		logic tick_b;
		logic tick_a;
	} pts_ticks_s;

	typedef enum logic [2:0] {
		PTS_W_IDLE = 3'b001,
		PTS_W_RESP = 3'b010,
		PTS_W_HOLD = 3'b100
	} pts_wstate_e;
endpackage

// ==== pts_timebase_select.sv ====
// pwm time base selection register with axi4-lite slave
// What this block does
// - channel 4 time base from timer picked by bits 7-6; 00 a, 01 b, 10 c.
// - channel 3 time base from timer picked by bits 5-4; 00 a, 01 b, 10 c.
// - channel 2 time base from timer picked by bits 3-2; 00 a, 01 b, 10 c.
// - channel 1 time base from timer picked by bits 1-0; 00 a, 01 b, 10 c.
`timescale 1ns/1ns
module pts_timebase_select (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// axi4-lite write address and data
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// period timer ticks and pwm mode per channel
	input wire pts_pkg::pts_ticks_s timer_ticks,
	input wire logic [3:0] pwm_mode,
	// time base ticks, channel 1 in bit 0
	output logic [3:0] chan_tick
);
	logic [7:0] choice_q;
	logic [7:0] choice_d;
	logic aw_got_q;
	logic w_got_q;
	logic [3:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [3:0] mux_tick;

	wire logic aw_take;
	wire logic w_take;
	wire logic both_held;
	wire logic wr_hit;
	wire logic ar_take;
	wire logic [31:0] rd_word;
	wire logic rd_hit;
	wire logic [3:0] status_bits;
	wire logic [1:0] sel [0:3];

	// address and data may come in either order; each is latched until both are here
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready = !w_got_q && !bvalid_q;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign both_held = aw_got_q && w_got_q;
	assign wr_hit = awaddr_q == pts_pkg::REG_CHOICE0_OFS;
	assign choice_d = (both_held && wr_hit && wstrb0_q) ? wdata_q : choice_q;

	// bus write lands in the selector fields
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			choice_q <= pts_pkg::CHOICE0_RESET;
		end else begin
			choice_q <= choice_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_got_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[3:2], 2'h0};
			end else if (both_held) begin
				aw_got_q <= 1'b0;
			end
			if (w_take) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end else if (both_held) begin
				w_got_q <= 1'b0;
			end
		end
	end

	// status register is read only, so writing it is an error
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bvalid_q <= 1'b0;
			bresp_q <= pts_pkg::RESP_OKAY;
		end else if (both_held) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? pts_pkg::RESP_OKAY : pts_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// read side: status shows which channels are in pwm mode with a reserved code
	assign s_axi_arready = !rvalid_q;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign rd_hit = s_axi_araddr[3:2] == pts_pkg::REG_CHOICE0_OFS[3:2] ||
		s_axi_araddr[3:2] == pts_pkg::REG_STATUS_OFS[3:2];
	assign rd_word = (s_axi_araddr[3:2] == pts_pkg::REG_CHOICE0_OFS[3:2]) ? {24'h000000, choice_q} :
		(s_axi_araddr[3:2] == pts_pkg::REG_STATUS_OFS[3:2]) ? {28'h0000000, status_bits} : 32'h00000000;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= pts_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_hit ? pts_pkg::RESP_OKAY : pts_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	assign sel[3] = choice_q[pts_pkg::CHAN4_LSB +: 2];
	assign sel[2] = choice_q[pts_pkg::CHAN3_LSB +: 2];
	assign sel[1] = choice_q[pts_pkg::CHAN2_LSB +: 2];
	assign sel[0] = choice_q[pts_pkg::CHAN1_LSB +: 2];

	genvar gi;
	generate
		for (gi = 0; gi < pts_pkg::NUM_CHAN; gi++) begin : g_chan
			assign status_bits[gi] = pwm_mode[gi] && (sel[gi] == pts_pkg::SEL_RSVD);
			pts_chan_mux u_mux (
				.ref_clk(ref_clk),
				.srst(srst),
				.sel(sel[gi]),
				.ticks(timer_ticks),
				.tick_out(mux_tick[gi])
			);
			// outside pwm mode the channel gets no time base
			assign chan_tick[gi] = mux_tick[gi] && pwm_mode[gi];
		end
	endgenerate

	a_reset_clears: assert property (@(posedge ref_clk) srst |=> choice_q == pts_pkg::CHOICE0_RESET)
		else $error("selector not cleared by reset");
	a_write_lands: assert property (@(posedge ref_clk) disable iff (srst)
		(both_held && wr_hit && wstrb0_q) |=> choice_q == $past(wdata_q))
		else $error("write did not reach selector");
	// sampled reset keeps the first edge after release out, the mux still shows its reset value there
	a_chan4_tmr_c: assert property (@(posedge ref_clk) disable iff (srst)
		(!srst && pwm_mode[3] && sel[3] == pts_pkg::SEL_TMR_C) ##1 pwm_mode[3]
		|-> chan_tick[3] == $past(timer_ticks.tick_c))
		else $error("channel 4 not on timer c");
	a_chan4_tmr_b: assert property (@(posedge ref_clk) disable iff (srst)
		(!srst && pwm_mode[3] && sel[3] == pts_pkg::SEL_TMR_B) ##1 pwm_mode[3]
		|-> chan_tick[3] == $past(timer_ticks.tick_b))
		else $error("channel 4 not on timer b");
	a_chan3_tmr_b: assert property (@(posedge ref_clk) disable iff (srst)
		(!srst && pwm_mode[2] && sel[2] == pts_pkg::SEL_TMR_B) ##1 pwm_mode[2]
		|-> chan_tick[2] == $past(timer_ticks.tick_b))
		else $error("channel 3 not on timer b");
	a_chan3_tmr_c: assert property (@(posedge ref_clk) disable iff (srst)
		(!srst && pwm_mode[2] && sel[2] == pts_pkg::SEL_TMR_C) ##1 pwm_mode[2]
		|-> chan_tick[2] == $past(timer_ticks.tick_c))
		else $error("channel 3 not on timer c");
	a_chan2_tmr_a: assert property (@(posedge ref_clk) disable iff (srst)
		(!srst && pwm_mode[1] && sel[1] == pts_pkg::SEL_TMR_A) ##1 pwm_mode[1]
		|-> chan_tick[1] == $past(timer_ticks.tick_a))
		else $error("channel 2 not on timer a");
	a_chan2_tmr_b: assert property (@(posedge ref_clk) disable iff (srst)
		(!srst && pwm_mode[1] && sel[1] == pts_pkg::SEL_TMR_B) ##1 pwm_mode[1]
		|-> chan_tick[1] == $past(timer_ticks.tick_b))
		else $error("channel 2 not on timer b");
	a_chan1_tmr_c: assert property (@(posedge ref_clk) disable iff (srst)
		(!srst && pwm_mode[0] && sel[0] == pts_pkg::SEL_TMR_C) ##1 pwm_mode[0]
		|-> chan_tick[0] == $past(timer_ticks.tick_c))
		else $error("channel 1 not on timer c");
	a_chan1_tmr_b: assert property (@(posedge ref_clk) disable iff (srst)
		(!srst && pwm_mode[0] && sel[0] == pts_pkg::SEL_TMR_B) ##1 pwm_mode[0]
		|-> chan_tick[0] == $past(timer_ticks.tick_b))
		else $error("channel 1 not on timer b");
	a_rsvd_fallback: assert property (@(posedge ref_clk) disable iff (srst)
		(!srst && pwm_mode[0] && sel[0] == pts_pkg::SEL_RSVD) ##1 pwm_mode[0]
		|-> chan_tick[0] == $past(timer_ticks.tick_a))
		else $error("reserved code not on timer a");
	a_bresp_follows: assert property (@(posedge ref_clk) disable iff (srst)
		both_held |=> s_axi_bvalid)
		else $error("no write response");
	a_write_error: assert property (@(posedge ref_clk) disable iff (srst)
		(both_held && !wr_hit) |=> s_axi_bresp == pts_pkg::RESP_SLVERR)
		else $error("unmapped write not refused");
	a_choice_steady: assert property (@(posedge ref_clk) disable iff (srst)
		!(both_held && wr_hit && wstrb0_q) |=> $stable(choice_q))
		else $error("selector changed without write");
	a_ready_low: assert property (@(posedge ref_clk) disable iff (srst)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_rvalid_holds: assert property (@(posedge ref_clk) disable iff (srst)
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_error: assert property (@(posedge ref_clk) disable iff (srst)
		(ar_take && !rd_hit) |=> s_axi_rresp == pts_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	c_write_reg: cover property (@(posedge ref_clk) both_held && wr_hit);
	c_write_error: cover property (@(posedge ref_clk) both_held && !wr_hit);
	c_read_status: cover property (@(posedge ref_clk) ar_take && s_axi_araddr[3:2] == 2'h1);
	c_rsvd_seen: cover property (@(posedge ref_clk) |status_bits);
	c_all_timer_c: cover property (@(posedge ref_clk) choice_q == 8'haa && pwm_mode == 4'hf);
endmodule

// ==== testbench.sv ====
// self-checking bench for the pwm time base selection register
`timescale 1ns/1ns
module testbench;
	logic ref_clk = 0;
	logic srst = 1;
	logic [3:0] awaddr = 0, wstrb = 0, araddr = 0, pwm_mode = 0, chan_tick;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, tchk = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	pts_pkg::pts_ticks_s ticks = 0;
	logic [15:0] lf = 16'd8901;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [3:0] tq[$];
	int mismatches = 0, total_checks = 0;

	pts_timebase_select uut (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_ticks(ticks),
		.pwm_mode(pwm_mode), .chan_tick(chan_tick));

	always #25 ref_clk = ~ref_clk;

	function automatic logic [15:0] nx(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// reserved code falls through to timer a
	function automatic logic [3:0] etk(logic [7:0] c, pts_pkg::pts_ticks_s t, logic [3:0] m);
		logic [3:0] e;
		for (int n = 0; n < 4; n++) begin
			case (c[2*n+:2])
				pts_pkg::SEL_TMR_B: e[n] = t.tick_b;
				pts_pkg::SEL_TMR_C: e[n] = t.tick_c;
				default: e[n] = t.tick_a;
			endcase
		end
		return e & m;
	endfunction

	task chk(input string n, input logic [33:0] s, input logic [33:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		logic done;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		bq.push_back(r);
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			done = bvalid;
		end while (!done);
		bready <= 0;
	endtask

	task rd(input logic [3:0] a, input logic [33:0] e);
		logic done;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		rq.push_back(e);
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 0;
			done = rvalid;
		end while (!done);
		rready <= 0;
	endtask

	// one-hot ticks first so a wrong timer choice cannot hide
	task tk(input logic [7:0] c, input int j);
		pts_pkg::pts_ticks_s t;
		logic [3:0] m;
		lf = nx(lf);
		t = (j < 3) ? pts_pkg::pts_ticks_s'(3'h1 << j) : pts_pkg::pts_ticks_s'(lf[2:0]);
		m = (j < 3) ? 4'hf : lf[6:3];
		ticks <= t;
		pwm_mode <= m;
		repeat (2) @(posedge ref_clk);
		tq.push_back(etk(c, t, m));
		tchk <= 1;
		@(posedge ref_clk);
		tchk <= 0;
	endtask

	always @(posedge ref_clk) begin
		if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
		if (rvalid && rready) chk("rdata", {rresp, rdata}, rq.pop_front());
		if (tchk) chk("chan_tick", {30'h0, chan_tick}, {30'h0, tq.pop_front()});
	end

	initial begin
		logic [7:0] v;
		repeat (6) @(posedge ref_clk);
		srst <= 0;
		rd(pts_pkg::REG_CHOICE0_OFS, {pts_pkg::RESP_OKAY, 24'h0, pts_pkg::CHOICE0_RESET});
		$display("test reset value done");
		for (int i = 0; i < 20; i++) begin
			lf = nx(lf);
			v = (i < 4) ? {4{i[1:0]}} : lf[7:0];
			wr(pts_pkg::REG_CHOICE0_OFS, {lf, lf[7:0], v}, 4'hf, pts_pkg::RESP_OKAY);
			rd(pts_pkg::REG_CHOICE0_OFS, {pts_pkg::RESP_OKAY, 24'h0, v});
			for (int j = 0; j < 4; j++) tk(v, j);
		end
		$display("test field selection done");
		wr(pts_pkg::REG_CHOICE0_OFS, 32'h0000_00e4, 4'he, pts_pkg::RESP_OKAY);
		rd(pts_pkg::REG_CHOICE0_OFS, {pts_pkg::RESP_OKAY, 24'h0, v});
		wr(pts_pkg::REG_CHOICE0_OFS, 32'h0000_00ff, 4'hf, pts_pkg::RESP_OKAY);
		for (int j = 0; j < 4; j++) tk(8'hff, j);
		rd(pts_pkg::REG_STATUS_OFS, {pts_pkg::RESP_OKAY, 28'h0, pwm_mode});
		$display("test strobe and reserved code done");
		wr(4'h8, 32'h0, 4'hf, pts_pkg::RESP_SLVERR);
		wr(pts_pkg::REG_STATUS_OFS, 32'h0, 4'hf, pts_pkg::RESP_SLVERR);
		rd(4'h8, {pts_pkg::RESP_SLVERR, 32'h0});
		rd(pts_pkg::REG_CHOICE0_OFS, {pts_pkg::RESP_OKAY, 24'h0, 8'hff});
		$display("test unmapped access done");
		srst <= 1;
		repeat (2) @(posedge ref_clk);
		srst <= 0;
		rd(pts_pkg::REG_CHOICE0_OFS, {pts_pkg::RESP_OKAY, 24'h0, pts_pkg::CHOICE0_RESET});
		$display("test second reset done");
		end_of_test;
	end

	// the sequence needs well under a thousand cycles
	initial begin
		#200000;
		mismatches++;
		end_of_test;
	end
endmodule
